/* File: bench/far_side_controller.sv */
// Far-side controller model: link requests and a stalling record sink
module far_side_controller (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      rec_valid_i,
    input  wire line_monitor_pkg::in_rec_t rec_i,
    output logic                           link_req_o,
    output logic [15:0]                    link_master_o,
    output logic                           rec_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import line_monitor_pkg::*;

    // 0 always ready, 1 random stalls, 2 held off
    logic [1:0] ready_mode = 2'd0;
    int         rec_count  = 0;
    in_rec_t    last_rec   = '0;

    initial begin
        link_req_o = 1'b0;
        link_master_o = 16'h0000;
        rec_ready_o = 1'b1;
    end

    // A record is taken at the edge where valid and ready meet
    always @(posedge clk_i) begin
        if (!rst_i && rec_valid_i && rec_ready_o) begin
            last_rec <= rec_i;
            rec_count <= rec_count + 1;
        end
        rec_ready_o <= (ready_mode == 2'd0) || (ready_mode == 2'd1 && $urandom_range(1) == 1);
    end

    // The id is scrambled after the request so a stale value never looks valid
    task automatic request(input logic [15:0] id);
        @(posedge clk_i);
        link_req_o <= 1'b1;
        link_master_o <= id;
        @(posedge clk_i);
        link_req_o <= 1'b0;
        link_master_o <= ~id;
    endtask
endmodule

/* File: bench/test_line_monitored_input_unit.sv */
// Self-checking bench for the line-monitored input unit
module test_line_monitored_input_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import line_monitor_pkg::*;

    localparam int BLINK = 20;
    localparam int FRAME = SLOT_CYCLES * SLOTS_PER_FRAME;

    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [15:0]      pin, mon, raw, led, master;
    logic [15:0][1:0] mode, wsrc;
    src_sel_t         src;
    logic [2:0]       cnt, cnt_d;
    logic [3:0]       tpo;
    logic             variant, fault_led, rec_valid, bound, refused, req, ready;
    in_rec_t          rec;
    station_t         station;
    int               bad_count = 0;
    int               checked = 0;
    int               cyc = 0;

    always #5 clk = ~clk;

    line_monitored_input_unit #(.BLINK_CYCLES(BLINK)) line_monitored_input_unit_i (
        .CLK_I(clk), .SYS_RST_I(rst), .DIGITAL_INPUT_CHANNEL_I(pin), .LINE_MON_I(mon),
        .SRC_SEL_I(src), .PULSE_OUT_COUNT_I(cnt), .TOOL_VARIANT_I(variant),
        .LINK_REQ_I(req), .LINK_MASTER_I(master), .REC_READY_I(ready),
        .TEST_PULSE_OUTPUT_O(tpo), .CHAN_LED_O(led), .FAULT_LED_O(fault_led),
        .REC_VALID_O(rec_valid), .REC_O(rec), .LINK_BOUND_O(bound),
        .LINK_REFUSED_O(refused), .STATION_IDENTIFIER_O(station));

    far_side_controller far_side_controller_i (
        .clk_i(clk), .rst_i(rst), .rec_valid_i(rec_valid), .rec_i(rec),
        .link_req_o(req), .link_master_o(master), .rec_ready_o(ready));

    // Field wiring: loopback from a pulse output, stuck levels, or a static contact
    always_comb begin
        for (int c = 0; c < 16; c++) begin
            case (mode[c])
                2'd0: pin[c] = tpo[wsrc[c]];
                2'd1: pin[c] = 1'b0;
                2'd2: pin[c] = 1'b1;
                default: pin[c] = raw[c];
            endcase
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks made: %0d, mismatches: %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic pin_end(input int c);
        case (mode[c])
            2'd0: return wsrc[c] < cnt;
            2'd1: return 1'b0;
            2'd2: return 1'b1;
            default: return raw[c];
        endcase
    endfunction

    function automatic logic [1:0] exp_err(input int c);
        if (!mon[c]) return ERR_NONE;
        if (src[c] >= cnt) return ERR_CONFIG;
        if (mode[c] == 2'd0 && wsrc[c] == src[c]) return ERR_NONE;
        if (mode[c] == 2'd0) return (wsrc[c] < cnt) ? ERR_CROSS : ERR_OPEN;
        return (mode[c] == 2'd2 || (mode[c] == 2'd3 && raw[c])) ? ERR_CROSS : ERR_OPEN;
    endfunction

    // Slot timing is checked mid-slot so a one-cycle phase choice cannot matter
    always @(posedge clk) begin
        cyc <= rst ? 0 : cyc + 1;
        cnt_d <= cnt;
    end
    always @(negedge clk) begin
        if (!rst && cnt === cnt_d && cyc % SLOT_CYCLES == 50) begin
            // Unconfigured outputs stay low; configured ones drop only in their own slot
            for (int k = 0; k < 4; k++) begin
                check(tpo[k], k < cnt && (cyc / SLOT_CYCLES) % 8 != 2 * k);
            end
        end
    end

    // kind 0: healthy loopback, 1: random wiring faults, 2: static contacts
    task automatic setup(input logic [15:0] m, input logic [2:0] n, input int kind);
        logic [1:0] s;
        @(posedge clk);
        mon <= m;
        cnt <= n;
        raw <= 16'($urandom());
        for (int c = 0; c < 16; c++) begin
            s = (kind == 1) ? 2'($urandom()) : 2'(c);
            src[c] <= s;
            wsrc[c] <= (kind == 1 && $urandom_range(1) == 1) ? 2'($urandom()) : s;
            mode[c] <= (kind == 1) ? 2'($urandom()) : (kind == 2) ? 2'd3 : 2'd0;
        end
        repeat (3 * FRAME + 30) @(posedge clk);
    endtask

    task automatic expect_record();
        logic [15:0]      v, mask;
        logic [15:0][1:0] e;
        logic             seen0, seen1;
        seen0 = 1'b0;
        seen1 = 1'b0;
        for (int c = 0; c < 16; c++) begin
            e[c] = exp_err(c);
            v[c] = e[c] == ERR_NONE && pin_end(c);
            mask[c] = mode[c] != 2'd0;
        end
        @(negedge clk);
        check(far_side_controller_i.last_rec.value, v);
        check(far_side_controller_i.last_rec.err, e);
        check(far_side_controller_i.last_rec.master, 16'h0005);
        check(led & mask, pin & mask);
        repeat (2 * BLINK + 4) begin
            @(negedge clk);
            seen1 |= fault_led === 1'b1;
            seen0 |= fault_led === 1'b0;
        end
        check({seen1, seen0}, (|e) ? 2'b11 : 2'b01);
    endtask

    initial begin
        int n0;
        void'($urandom(32'h376a8f33));
        mon = 16'h0000;
        raw = 16'h0000;
        src = '0;
        cnt = 3'd4;
        cnt_d = 3'd4;
        mode = '0;
        wsrc = '0;
        variant = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(station, {NET_ADDR_RESET, STATION_RACK_RESET, STATION_SUB_NEW, 8'h00});
        setup(16'h0000, 3'd4, 2);
        check({bound, rec_valid, 32'(far_side_controller_i.rec_count)}, '0);
        far_side_controller_i.request(16'h0005);
        #1 check(bound, 1'b1);
        far_side_controller_i.request(16'h0007);
        #1 check(refused, 1'b1);
        @(posedge clk);
        #1 check(refused, 1'b0);
        far_side_controller_i.request(16'h0005);
        #1 check({bound, refused}, 2'b10);
        @(negedge clk) far_side_controller_i.ready_mode = 2'd1;
        setup(16'h0000, 3'd4, 2);
        expect_record();
        setup(16'hffff, 3'd4, 0);
        expect_record();
        setup(16'hffff, 3'd0, 0);
        expect_record();
        for (int i = 0; i < 6; i++) begin
            setup(16'($urandom()), 3'($urandom_range(4, 1)), 1);
            expect_record();
        end
        setup(16'hffff, 3'd4, 0);
        expect_record();
        // Hold the sink off until the buffer refuses, then drain it
        // Start mid-frame so no frame end falls inside the drain window
        wait (cyc % FRAME == FRAME / 2);
        @(negedge clk) far_side_controller_i.ready_mode = 2'd2;
        n0 = far_side_controller_i.rec_count;
        repeat (11 * FRAME) @(posedge clk);
        #1 check(rec_valid, 1'b1);
        far_side_controller_i.ready_mode = 2'd0;
        repeat (40) @(posedge clk);
        n0 = far_side_controller_i.rec_count - n0;
        #1 check({rec_valid, 1'(n0 >= 8 && n0 <= 10)}, 2'b01);
        rst <= 1'b1;
        variant <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check({station.sub, bound}, 9'h000);
        summarize();
    end

    initial begin
        #(60 * FRAME * CLK_PERIOD_NS);
        bad_count++;
        summarize();
    end
endmodule

/* File: src/line_monitor_pkg.sv */
// Constants, types and records shared by the line-monitored input unit
package line_monitor_pkg;

    localparam int NUM_CHAN        = 16;
    localparam int NUM_PULSE       = 4;
    localparam int FIFO_DEPTH      = 8;

    localparam int CLK_HZ          = 100_000_000;
    localparam int CLK_PERIOD_NS   = 10;

    // Test slot is a least time: round up to whole cycles
    localparam int SLOT_TIME_NS    = 1000;
    localparam int SLOT_CYCLES     = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_W          = 7;
    localparam int SLOTS_PER_FRAME = 8;

    // Fault indicator half period
    localparam int BLINK_TIME_MS     = 250;
    localparam int BLINK_CYCLES_DFLT = BLINK_TIME_MS * (CLK_HZ / 1000);
    localparam int BLINK_W           = 25;

    // Station identity after power-up
    localparam logic [31:0] NET_ADDR_RESET     = 32'hc0a8_0063;
    localparam logic [15:0] STATION_RACK_RESET = 16'hea60;
    localparam logic [7:0]  STATION_SUB_NEW    = 8'hc8;
    localparam logic [7:0]  STATION_SUB_OLD    = 8'h00;
    localparam logic [7:0]  STATION_SLOT_RESET = 8'h00;

    typedef enum logic [1:0] {
        ERR_NONE,
        ERR_OPEN,
        ERR_CROSS,
        ERR_CONFIG
    } err_code_t;

    // Per channel: index of the pulse output wired to it
    typedef logic [NUM_CHAN-1:0][1:0] src_sel_t;

    typedef struct packed {
        logic [15:0]               master;
        logic [NUM_CHAN-1:0]       value;
        logic [NUM_CHAN-1:0][1:0]  err;
    } in_rec_t;

    typedef struct packed {
        logic [31:0] net_addr;
        logic [15:0] rack;
        logic [7:0]  sub;
        logic [7:0]  slot;
    } station_t;

    typedef struct packed {
        logic [NUM_CHAN-1:0]       sync1;
        logic [NUM_CHAN-1:0]       sync2;
        logic                      var1;
        logic                      var2;
        logic [SLOT_W-1:0]         slot_cnt;
        logic [2:0]                slot;
        logic [BLINK_W-1:0]        blink_cnt;
        logic                      blink;
        logic [NUM_PULSE-1:0]      pulse;
        logic [NUM_CHAN-1:0]       acc_open;
        logic [NUM_CHAN-1:0]       acc_cross;
        logic [NUM_CHAN-1:0]       acc_cfg;
        logic [NUM_CHAN-1:0][1:0]  err;
        logic                      bound;
        logic [15:0]               owner;
        logic                      refused;
        logic                      push_valid;
        in_rec_t                   push_rec;
        logic                      out_valid;
        in_rec_t                   out_rec;
        logic [NUM_CHAN-1:0]       led;
        logic                      fault_led;
        station_t                  station;
    } unit_state_t;

endpackage

/* File: src/line_monitored_input_unit.sv */
// Input acquisition, line monitoring, record FIFO and top of the input unit
//
// Behaviour
// - Sixteen input channels, four pulsed outputs, one indicator per input.
// - Unmonitored channels are read as-is; an open line simply reads low.
// - A faulty channel is always reported low.
// - Any channel fault turns the common fault indicator on.
// - Each channel carries an error code next to its value.
// - With monitoring, pulse the outputs and check inputs against them.
// - Cross, miswire, earth or open fault: force low, blink, error code.
// - Default network address and station identifier per tool variant.
// - Only the first controlling master is served; others are refused.
// - No program of its own; input records are forwarded to the master.

module record_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t f;
    fifo_state_t next_f;
    logic        do_wr;
    logic        do_rd;

    assign in_ready_o  = f.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = f.cnt != '0;
    assign out_data_o  = f.mem[f.rd];

    always_comb begin
        next_f = f;
        do_wr  = in_valid_i && in_ready_o;
        do_rd  = out_valid_o && out_ready_i;
        if (do_wr) begin
            next_f.mem[f.wr] = in_data_i;
            next_f.wr        = f.wr + 1'b1;
        end
        if (do_rd) begin
            next_f.rd = f.rd + 1'b1;
        end
        next_f.cnt = f.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        if (rst_i) begin
            next_f = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        f <= next_f;
    end
endmodule

module line_monitored_input_unit #(
    parameter int BLINK_CYCLES = line_monitor_pkg::BLINK_CYCLES_DFLT
) (
    input  wire logic                      CLK_I,
    input  wire logic                      SYS_RST_I,
    input  wire logic [15:0]               DIGITAL_INPUT_CHANNEL_I,
    input  wire logic [15:0]               LINE_MON_I,
    input  wire line_monitor_pkg::src_sel_t SRC_SEL_I,
    input  wire logic [2:0]                PULSE_OUT_COUNT_I,
    input  wire logic                      TOOL_VARIANT_I,
    input  wire logic                      LINK_REQ_I,
    input  wire logic [15:0]               LINK_MASTER_I,
    input  wire logic                      REC_READY_I,
    output logic [3:0]                     TEST_PULSE_OUTPUT_O,
    output logic [15:0]                    CHAN_LED_O,
    output logic                           FAULT_LED_O,
    output logic                           REC_VALID_O,
    output line_monitor_pkg::in_rec_t      REC_O,
    output logic                           LINK_BOUND_O,
    output logic                           LINK_REFUSED_O,
    output line_monitor_pkg::station_t     STATION_IDENTIFIER_O
);
    import line_monitor_pkg::*;

    unit_state_t          s;
    unit_state_t          next_s;
    logic                 slot_end;
    logic                 frame_end;
    logic [NUM_CHAN-1:0]  chk_open;
    logic [NUM_CHAN-1:0]  chk_cross;
    logic [NUM_CHAN-1:0]  chk_cfg;
    in_rec_t              frame_rec;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_out_ready;
    in_rec_t              fifo_out_data;

    function automatic logic [NUM_PULSE-1:0] cnt_mask(input logic [2:0] cnt);
        logic [NUM_PULSE-1:0] m;
        m = '0;
        for (int k = 0; k < NUM_PULSE; k++) begin
            m[k] = 3'(k) < cnt;
        end
        return m;
    endfunction

    // Configured output k is pulled low during slot 2k only, so no two configured ones are low together; unconfigured outputs stay low
    function automatic logic [NUM_PULSE-1:0] pulse_pattern(input logic [2:0] slot,
                                                           input logic [2:0] cnt);
        logic [NUM_PULSE-1:0] p;
        p = cnt_mask(cnt);
        for (int k = 0; k < NUM_PULSE; k++) begin
            if (slot == 3'(2 * k)) begin
                p[k] = 1'b0;
            end
        end
        return p;
    endfunction

    function automatic logic [1:0] err_code(input logic open, input logic crossed,
                                            input logic cfg);
        logic [1:0] e;
        e = ERR_NONE;
        if (cfg) begin
            e = ERR_CONFIG;
        end else if (crossed) begin
            e = ERR_CROSS;
        end else if (open) begin
            e = ERR_OPEN;
        end
        return e;
    endfunction

    function automatic logic [NUM_CHAN-1:0] err_mask(input logic [NUM_CHAN-1:0][1:0] e);
        logic [NUM_CHAN-1:0] m;
        m = '0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            m[c] = e[c] != ERR_NONE;
        end
        return m;
    endfunction

    assign fifo_out_ready = !s.out_valid || REC_READY_I;

    record_fifo #(
        .WIDTH ($bits(in_rec_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (s.push_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (s.push_rec),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    always_comb begin
        next_s    = s;
        frame_rec = '0;
        next_s.sync1   = DIGITAL_INPUT_CHANNEL_I;
        next_s.sync2   = s.sync1;
        next_s.var1    = TOOL_VARIANT_I;
        next_s.var2    = s.var1;
        next_s.led     = s.sync2;
        next_s.refused = 1'b0;

        slot_end  = s.slot_cnt == SLOT_W'(SLOT_CYCLES - 1);
        frame_end = slot_end && (s.slot == 3'(SLOTS_PER_FRAME - 1));
        next_s.slot_cnt = slot_end ? '0 : s.slot_cnt + 1'b1;
        if (slot_end) begin
            next_s.slot = s.slot + 3'h1;
        end
        next_s.pulse = pulse_pattern(next_s.slot, PULSE_OUT_COUNT_I);

        // Input checked late in the slot, long after the synchroniser delay
        for (int c = 0; c < NUM_CHAN; c++) begin
            chk_cfg[c]   = LINE_MON_I[c] && ({1'b0, SRC_SEL_I[c]} >= PULSE_OUT_COUNT_I);
            chk_open[c]  = LINE_MON_I[c] && !chk_cfg[c] && s.pulse[SRC_SEL_I[c]]
                           && !s.sync2[c];
            chk_cross[c] = LINE_MON_I[c] && !chk_cfg[c] && !s.pulse[SRC_SEL_I[c]]
                           && s.sync2[c];
        end
        if (slot_end) begin
            next_s.acc_open  = s.acc_open | chk_open;
            next_s.acc_cross = s.acc_cross | chk_cross;
            next_s.acc_cfg   = s.acc_cfg | chk_cfg;
        end

        frame_rec.master = s.owner;
        for (int c = 0; c < NUM_CHAN; c++) begin
            frame_rec.err[c]   = err_code(next_s.acc_open[c], next_s.acc_cross[c],
                                          next_s.acc_cfg[c]);
            // Unmonitored channels pass straight through
            frame_rec.value[c] = (frame_rec.err[c] == ERR_NONE) && s.sync2[c];
        end
        if (frame_end) begin
            // A fault clears only after one whole clean frame
            next_s.err       = frame_rec.err;
            next_s.acc_open  = '0;
            next_s.acc_cross = '0;
            next_s.acc_cfg   = '0;
        end

        if (s.blink_cnt == BLINK_W'(BLINK_CYCLES - 1)) begin
            next_s.blink_cnt = '0;
            next_s.blink     = !s.blink;
        end else begin
            next_s.blink_cnt = s.blink_cnt + 1'b1;
        end
        next_s.fault_led = (|err_mask(s.err)) && s.blink;

        if (LINK_REQ_I) begin
            if (!s.bound) begin
                next_s.bound = 1'b1;
                next_s.owner = LINK_MASTER_I;
            end else if (LINK_MASTER_I != s.owner) begin
                next_s.refused = 1'b1;
            end
        end

        // A pending record blocks the next snapshot until the FIFO takes it
        if (s.push_valid && fifo_in_ready) begin
            next_s.push_valid = 1'b0;
        end
        if (frame_end && s.bound && !next_s.push_valid) begin
            next_s.push_valid = 1'b1;
            next_s.push_rec   = frame_rec;
        end

        if (fifo_out_valid && fifo_out_ready) begin
            next_s.out_valid = 1'b1;
            next_s.out_rec   = fifo_out_data;
        end else if (REC_READY_I) begin
            next_s.out_valid = 1'b0;
        end

        if (SYS_RST_I) begin
            next_s       = '0;
            next_s.sync1 = DIGITAL_INPUT_CHANNEL_I;
            next_s.sync2 = s.sync1;
            next_s.var1  = TOOL_VARIANT_I;
            next_s.var2  = s.var1;
            // Strap caught through the synchroniser while reset is held
            next_s.station.net_addr = NET_ADDR_RESET;
            next_s.station.rack     = STATION_RACK_RESET;
            next_s.station.sub      = s.var2 ? STATION_SUB_NEW : STATION_SUB_OLD;
            next_s.station.slot     = STATION_SLOT_RESET;
        end
    end

    always_ff @(posedge CLK_I) begin
        s <= next_s;
    end

    assign TEST_PULSE_OUTPUT_O  = s.pulse;
    assign CHAN_LED_O           = s.led;
    assign FAULT_LED_O          = s.fault_led;
    assign REC_VALID_O          = s.out_valid;
    assign REC_O                = s.out_rec;
    assign LINK_BOUND_O         = s.bound;
    assign LINK_REFUSED_O       = s.refused;
    assign STATION_IDENTIFIER_O = s.station;

    logic [1:0] since_rst;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            since_rst <= '0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_led_follows_pin: assert property (since_rst == 2'h3 |->
        CHAN_LED_O == $past(DIGITAL_INPUT_CHANNEL_I, 3))
        else $error("channel indicator does not follow its input");
    a_faulty_reads_low: assert property (REC_VALID_O |->
        (REC_O.value & err_mask(REC_O.err)) == '0)
        else $error("faulty channel reported high");
    a_led_dark_clean: assert property (!(|err_mask(s.err)) |=> !FAULT_LED_O)
        else $error("fault indicator lit without a fault");
    a_pulse_unused_low: assert property (since_rst == 2'h3 |->
        (TEST_PULSE_OUTPUT_O & ~cnt_mask($past(PULSE_OUT_COUNT_I))) == '0)
        else $error("unconfigured pulse output driven");
    a_pulse_one_low: assert property (since_rst == 2'h3 |->
        $countones(~TEST_PULSE_OUTPUT_O & cnt_mask($past(PULSE_OUT_COUNT_I))) <= 1)
        else $error("two pulse outputs low together");
    a_cfg_error_code: assert property (frame_end && LINE_MON_I[0]
        && ({1'b0, SRC_SEL_I[0]} >= PULSE_OUT_COUNT_I) |=> s.err[0] == ERR_CONFIG)
        else $error("bad pulse source not flagged");
    a_refuse_foreign: assert property (LINK_REQ_I && s.bound && (LINK_MASTER_I != s.owner)
        |=> LINK_REFUSED_O ##1 (!LINK_REFUSED_O || $past(LINK_REQ_I)))
        else $error("second master not refused");
    a_owner_stable: assert property (LINK_BOUND_O |=> LINK_BOUND_O && $stable(s.owner))
        else $error("bound master changed");
    a_rec_hold: assert property (REC_VALID_O && !REC_READY_I |=>
        REC_VALID_O && $stable(REC_O))
        else $error("record dropped while stalled");
    a_station_addr: assert property (STATION_IDENTIFIER_O.net_addr == NET_ADDR_RESET
        && STATION_IDENTIFIER_O.rack == STATION_RACK_RESET)
        else $error("station identity lost");

    c_refused: cover property (LINK_REFUSED_O);
    c_record_out: cover property (REC_VALID_O && REC_READY_I);
    c_fault_blink: cover property (FAULT_LED_O ##1 !FAULT_LED_O);
    c_backpressure: cover property (frame_end && s.push_valid && !fifo_in_ready);
endmodule
